/* legacy_view_pkg.sv */
// package: types and constants for the legacy 16-bit register view
package legacy_view_pkg;

  // page-zero word offsets of the narrow stack parameters (octal 40..43)
  localparam logic [15:0] PZ_STACK_PTR   = 16'h0020;
  localparam logic [15:0] PZ_FRAME_PTR   = 16'h0021;
  localparam logic [15:0] PZ_STACK_LIMIT = 16'h0022;
  localparam logic [15:0] PZ_STACK_FAULT = 16'h0023;
  // upper address bits above the 64k window of a segment
  localparam logic [11:0] SEG_FILL       = 12'h000;

  // float status register: legacy fields and reserved bit
  localparam int FSR_HI_LSB   = 48;
  localparam int FSR_RSV_BIT  = 15;
  localparam int FSR_LO_WIDTH = 15;

  // reset values
  localparam logic [31:0] ACC_RST   = 32'h0000_0000;
  localparam logic [63:0] FLT_RST   = 64'h0000_0000_0000_0000;
  localparam logic [15:0] PSR_RST   = 16'h0000;
  localparam logic        CARRY_RST = 1'b0;

  // native-side register select codes
  localparam logic [3:0] SEL_ACC0 = 4'h0;
  localparam logic [3:0] SEL_WIDE0 = 4'h4;
  localparam logic [3:0] SEL_PSR  = 4'h8;

  typedef enum logic [4:0] {
    op_none, op_load, op_read, op_add, op_sub, op_div, op_rel_addr,
    op_extended_subroutine_jump, op_extended_load_effective_addr,
    op_read_high_word, op_subroutine_jump, op_load_effective_addr,
    op_compare_to_limits, op_fp_load, op_fp_read, op_fsr_write, op_fsr_read,
    op_push, op_pop, op_rd_frame, op_wr_frame
  } op_t;

  typedef struct packed {
    op_t         op;
    logic [1:0]  dst;
    logic [1:0]  src;
    logic [31:0] data;
    logic [63:0] fdata;
  } leg_op_t;

  typedef struct packed {
    logic        valid;
    logic        we;
    logic [31:0] addr;
    logic [15:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic        we;
    logic [3:0]  sel;
    logic [31:0] data;
  } native_wr_t;

endpackage

/* legacy_alu.sv */
// legacy 16-bit arithmetic with carry taken at the 16-bit boundary
`timescale 1ns/1ps
`default_nettype none
module legacy_alu (
  input  var legacy_view_pkg::op_t op,
  input  wire logic [15:0]         a,
  input  wire logic [15:0]         b,
  input  wire logic                carry_in,
  output logic      [15:0]         res,
  output logic                     carry_out,
  output logic                     wr_en
);
  import legacy_view_pkg::*;

  logic [16:0] sum;

  always_comb begin
    sum       = 17'h0_0000;
    res       = a;
    carry_out = carry_in;
    wr_en     = 1'b0;
    unique case (op)
      op_add: begin
        sum       = {1'b0, a} + {1'b0, b};
        res       = sum[15:0];
        carry_out = sum[16]; // RQ15 RQ16
        wr_en     = 1'b1;
      end
      op_sub: begin
        sum       = {1'b0, a} + {1'b0, ~b} + 17'h0_0001;
        res       = sum[15:0];
        carry_out = sum[16]; // RQ15
        wr_en     = 1'b1;
      end
      op_div: begin
        // divide by zero leaves the destination alone and flags carry
        if (b == 16'h0000) begin
          carry_out = 1'b1; // RQ16
        end else begin
          res       = a / b;
          carry_out = 1'b0;
          wr_en     = 1'b1;
        end
      end
      default: begin
      end
    endcase
  end
endmodule
`default_nettype wire

/* fsr_view.sv */
// legacy 32-bit window onto the 64-bit float status register
`timescale 1ns/1ps
`default_nettype none
module fsr_view (
  input  wire logic [63:0] fsr_full,
  input  wire logic [31:0] leg_wdata,
  output logic      [31:0] leg_rdata,
  output logic      [63:0] fsr_merged
);
  import legacy_view_pkg::*;

  // bit 0 of the documented numbering is the msb here
  always_comb begin
    leg_rdata  = {fsr_full[63:FSR_HI_LSB], 1'b0,
                  fsr_full[FSR_LO_WIDTH-1:0]}; // RQ13 RQ14
    fsr_merged = {leg_wdata[31:16], fsr_full[FSR_HI_LSB-1:FSR_RSV_BIT+1],
                  1'b0, leg_wdata[FSR_LO_WIDTH-1:0]}; // RQ13 RQ14
  end
endmodule
`default_nettype wire

/* legacy_register_view.sv */
// legacy 16-bit view of the architectural registers and narrow stack
//
// Behaviour
// RQ1: legacy accumulator bits 0-15 are bits 16-31 of the 32-bit accumulator.
// RQ2: a legacy load writes bits 16-31 and leaves 0-15 undefined unless defined.
// RQ3: the five jump and load-address style ops define the whole accumulator.
// RQ4: an op that only reads an accumulator, like compare to limits, keeps it.
// RQ5: accumulator-relative offset is the 15 bits 17-31 of the accumulator.
// RQ6: legacy ops raise no fixed-point fault and never touch the status word.
// RQ7: legacy stack ops use the page-zero narrow stack, not the wide registers.
// RQ8: the narrow stack pointer lives at page-zero word 40 octal.
// RQ9: the narrow frame pointer lives at page-zero word 41 octal.
// RQ10: the narrow stack limit is read from page-zero word 42 octal.
// RQ11: a narrow stack fault fetches its handler from word 43 with indirection.
// RQ12: legacy float ops use the same four 64-bit float accumulators unchanged.
// RQ13: the legacy float status is bits 0-15 and 49-63 of the 64-bit register.
// RQ14: bit 48 of the float status register always reads as zero.
// RQ15: legacy carry comes from the carry out of accumulator bit 16.
// RQ16: add, subtract and divide update carry so software can see overflow.
// RQ17: an undefined upper half on a legacy load keeps its old contents.
`timescale 1ns/1ps
`default_nettype none
module legacy_register_view (
  input  wire logic                        mclk,
  input  wire logic                        srst,
  input  wire logic                        op_valid,
  input  var legacy_view_pkg::leg_op_t     op_in,
  output logic                             op_ready,
  output logic                             op_done,
  output logic      [31:0]                 rd_data,
  output logic      [14:0]                 rel_offset,
  output logic                             in_limits,
  output logic      [63:0]                 fp_rd_data,
  output logic                             carry,
  output logic                             fixed_fault,
  input  wire logic [2:0]                  cur_segment,
  output legacy_view_pkg::mem_req_t        mem_req,
  input  wire logic                        mem_ack,
  input  wire logic [15:0]                 mem_rdata,
  output logic                             stack_fault,
  output logic      [14:0]                 stack_fault_handler,
  input  var legacy_view_pkg::native_wr_t  native_wr,
  input  wire logic [1:0]                  fp_wr_sel,
  input  wire logic                        fp_wr_en,
  input  wire logic [63:0]                 fp_wr_data,
  output logic      [15:0]                 processor_status_word,
  output logic      [31:0]                 wide_frame_pointer,
  output logic      [31:0]                 wide_stack_pointer,
  output logic      [31:0]                 wide_stack_limit,
  output logic      [31:0]                 wide_stack_base,
  output logic      [31:0]                 fixed_acc_zero,
  output logic      [31:0]                 fixed_acc_one,
  output logic      [31:0]                 fixed_acc_two,
  output logic      [31:0]                 fixed_acc_three,
  output logic      [63:0]                 float_status_word
);
  import legacy_view_pkg::*;

  typedef enum logic [7:0] {
    st_idle     = 8'h01,
    st_rd_sp    = 8'h02,
    st_rd_lim   = 8'h04,
    st_wr_data  = 8'h08,
    st_rd_data  = 8'h10,
    st_wr_sp    = 8'h20,
    st_rd_vec   = 8'h40,
    st_frame    = 8'h80
  } state_t;

  state_t      state_r;
  state_t      state_nxt;
  leg_op_t     cur_r;
  logic [15:0] sp_r;
  logic [15:0] lim_r;
  logic [15:0] vec_addr_r;
  logic [31:0] acc_r [4];
  logic [63:0] flt_r [4];
  logic [31:0] wide_r [4];
  logic [63:0] fsr_r;
  logic [15:0] psr_r;
  logic        carry_r;
  logic [31:0] rd_data_r;
  logic [14:0] rel_offset_r;
  logic        in_limits_r;
  logic [63:0] fp_rd_data_r;
  logic        done_r;
  logic        fault_r;
  logic [14:0] fault_handler_r;

  logic        take;
  logic [15:0] dst_lo;
  logic [15:0] src_lo;
  logic [15:0] alu_res;
  logic        alu_carry;
  logic        alu_wr;
  logic [31:0] fsr_leg_rd;
  logic [63:0] fsr_merged;
  logic [15:0] sp_inc;
  logic        pop_wr;
  logic [15:0] mem_off;

  assign take     = op_valid && (state_r == st_idle);
  assign op_ready = (state_r == st_idle);
  assign dst_lo   = acc_r[op_in.dst][15:0]; // RQ1
  assign src_lo   = acc_r[op_in.src][15:0]; // RQ1
  assign sp_inc   = sp_r + 16'h0001;
  assign pop_wr   = (state_r == st_rd_data) && mem_ack;

  legacy_alu u_alu (
    .op        (take ? op_in.op : op_none),
    .a         (dst_lo),
    .b         (src_lo),
    .carry_in  (carry_r),
    .res       (alu_res),
    .carry_out (alu_carry),
    .wr_en     (alu_wr)
  );

  fsr_view u_fsr (
    .fsr_full   (fsr_r),
    .leg_wdata  (op_in.data),
    .leg_rdata  (fsr_leg_rd),
    .fsr_merged (fsr_merged)
  );

  // fixed-point accumulators: legacy writes land in the low 16 bits, except the five jump and load-address ops, which write all 32
  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int i = 0; i < 4; i++) begin
        acc_r[i] <= ACC_RST;
      end
    end else if (native_wr.we && native_wr.sel < SEL_WIDE0) begin
      acc_r[native_wr.sel[1:0]] <= native_wr.data;
    end else if (pop_wr) begin
      acc_r[cur_r.dst][15:0] <= mem_rdata; // RQ2 RQ17
    end else if ((state_r == st_frame) && mem_ack && !cur_r.data[0]) begin
      acc_r[cur_r.dst][15:0] <= mem_rdata; // RQ9 RQ17
    end else if (take) begin
      unique case (op_in.op)
        op_load: acc_r[op_in.dst][15:0] <= op_in.data[15:0]; // RQ2 RQ17
        op_add, op_sub, op_div: begin
          if (alu_wr) begin
            acc_r[op_in.dst][15:0] <= alu_res; // RQ2
          end
        end
        op_extended_subroutine_jump, op_extended_load_effective_addr,
        op_read_high_word, op_subroutine_jump, op_load_effective_addr: begin
          acc_r[op_in.dst] <= op_in.data; // RQ3
        end
        default: begin
          // reads, compare and relative addressing leave the source alone
        end // RQ4
      endcase
    end
  end

  // carry: only legacy add, subtract and divide change it
  always_ff @(posedge mclk) begin
    if (srst) begin
      carry_r <= CARRY_RST;
    end else if (take && (op_in.op inside {op_add, op_sub, op_div})) begin
      carry_r <= alu_carry; // RQ15 RQ16
    end
  end

  // status word and wide stack registers: native side only
  always_ff @(posedge mclk) begin
    if (srst) begin
      psr_r <= PSR_RST;
      for (int i = 0; i < 4; i++) begin
        wide_r[i] <= ACC_RST;
      end
    end else if (native_wr.we) begin
      if (native_wr.sel == SEL_PSR) begin
        psr_r <= native_wr.data[15:0]; // RQ6
      end else if (native_wr.sel >= SEL_WIDE0 && native_wr.sel < SEL_PSR) begin
        wide_r[native_wr.sel[1:0]] <= native_wr.data; // RQ7
      end
    end
  end

  // float accumulators shared as-is with the native instruction set
  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int i = 0; i < 4; i++) begin
        flt_r[i] <= FLT_RST;
      end
    end else if (take && op_in.op == op_fp_load) begin
      flt_r[op_in.dst] <= op_in.fdata; // RQ12
    end else if (fp_wr_en) begin
      flt_r[fp_wr_sel] <= fp_wr_data; // RQ12
    end
  end

  // float status: legacy writes reach only their own bits
  always_ff @(posedge mclk) begin
    if (srst) begin
      fsr_r <= FLT_RST;
    end else if (take && op_in.op == op_fsr_write) begin
      fsr_r <= fsr_merged; // RQ13 RQ14
    end
  end

  // read results held until the next read
  always_ff @(posedge mclk) begin
    if (srst) begin
      rd_data_r    <= ACC_RST;
      rel_offset_r <= 15'h0000;
      in_limits_r  <= 1'b0;
      fp_rd_data_r <= FLT_RST;
    end else if (take) begin
      unique case (op_in.op)
        op_read:      rd_data_r <= {16'h0000, dst_lo}; // RQ4
        op_rel_addr:  rel_offset_r <= acc_r[op_in.dst][14:0]; // RQ5
        op_compare_to_limits: begin
          // signed bounds: low in data[15:0], high in data[31:16]
          in_limits_r <= ($signed(dst_lo) >= $signed(op_in.data[15:0])) &&
                         ($signed(dst_lo) <= $signed(op_in.data[31:16])); // RQ4
        end
        op_fp_read:   fp_rd_data_r <= flt_r[op_in.src]; // RQ12
        op_fsr_read:  rd_data_r <= fsr_leg_rd; // RQ13 RQ14
        default: begin
        end
      endcase
    end
  end

  // narrow stack sequencer over page-zero memory
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      st_idle: begin
        if (take) begin
          if (op_in.op inside {op_push, op_pop}) begin
            state_nxt = st_rd_sp;
          end else if (op_in.op inside {op_rd_frame, op_wr_frame}) begin
            state_nxt = st_frame;
          end
        end
      end
      st_rd_sp: begin
        if (mem_ack) begin
          state_nxt = (cur_r.op == op_push) ? st_rd_lim : st_rd_data;
        end
      end
      st_rd_lim: begin
        if (mem_ack) begin
          state_nxt = (sp_inc > mem_rdata) ? st_rd_vec : st_wr_data; // RQ10
        end
      end
      st_wr_data: if (mem_ack) state_nxt = st_wr_sp;
      st_rd_data: if (mem_ack) state_nxt = st_wr_sp;
      st_wr_sp:   if (mem_ack) state_nxt = st_idle;
      st_rd_vec: begin
        // bit 15 marks an indirect pointer: keep fetching until it clears
        if (mem_ack && !mem_rdata[15]) begin
          state_nxt = st_idle; // RQ11
        end
      end
      st_frame:   if (mem_ack) state_nxt = st_idle;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_r <= st_idle;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      cur_r      <= '0;
      sp_r       <= 16'h0000;
      lim_r      <= 16'h0000;
      vec_addr_r <= PZ_STACK_FAULT;
    end else begin
      if (take) begin
        cur_r <= op_in;
        // frame direction rides in data bit 0: set means write
        cur_r.data[0] <= (op_in.op == op_wr_frame);
        cur_r.data[15:1] <= acc_r[op_in.src][15:1];
        vec_addr_r <= PZ_STACK_FAULT; // RQ11
      end
      if (state_r == st_rd_sp && mem_ack) begin
        sp_r <= mem_rdata; // RQ8
      end
      if (state_r == st_rd_lim && mem_ack) begin
        lim_r <= mem_rdata; // RQ10
      end
      if (state_r == st_wr_data && mem_ack) begin
        sp_r <= sp_inc;
      end
      if (state_r == st_rd_data && mem_ack) begin
        sp_r <= sp_r - 16'h0001;
      end
      if (state_r == st_rd_vec && mem_ack) begin
        vec_addr_r <= {1'b0, mem_rdata[14:0]}; // RQ11
      end
    end
  end

  // page-zero and stack addresses stay in the low 64k of the segment
  always_comb begin
    mem_off = PZ_STACK_PTR;
    unique case (state_r)
      st_rd_sp, st_wr_sp: mem_off = PZ_STACK_PTR; // RQ8
      st_rd_lim:          mem_off = PZ_STACK_LIMIT; // RQ10
      st_wr_data:         mem_off = sp_inc;
      st_rd_data:         mem_off = sp_r;
      st_rd_vec:          mem_off = vec_addr_r; // RQ11
      st_frame:           mem_off = PZ_FRAME_PTR; // RQ9
      default:            mem_off = PZ_STACK_PTR;
    endcase
    mem_req.valid = (state_r != st_idle); // RQ7
    mem_req.we    = (state_r inside {st_wr_data, st_wr_sp}) ||
                    ((state_r == st_frame) && cur_r.data[0]);
    mem_req.addr  = {1'b0, cur_segment, SEG_FILL, mem_off};
    mem_req.wdata = (state_r == st_wr_sp)   ? sp_r :
                    (state_r == st_frame)   ? {cur_r.data[15:1], 1'b0} :
                    acc_r[cur_r.src][15:0];
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      done_r          <= 1'b0;
      fault_r         <= 1'b0;
      fault_handler_r <= 15'h0000;
    end else begin
      done_r  <= (take && !(op_in.op inside {op_push, op_pop, op_rd_frame, op_wr_frame})) ||
                 ((state_r != st_idle) && (state_nxt == st_idle));
      fault_r <= (state_r == st_rd_vec) && (state_nxt == st_idle); // RQ11
      if ((state_r == st_rd_vec) && (state_nxt == st_idle)) begin
        fault_handler_r <= mem_rdata[14:0]; // RQ11
      end
    end
  end

  assign op_done               = done_r;
  assign rd_data               = rd_data_r;
  assign rel_offset            = rel_offset_r;
  assign in_limits             = in_limits_r;
  assign fp_rd_data            = fp_rd_data_r;
  assign carry                 = carry_r;
  assign fixed_fault           = 1'b0; // RQ6
  assign stack_fault           = fault_r;
  assign stack_fault_handler   = fault_handler_r;
  assign processor_status_word = psr_r;
  assign wide_frame_pointer    = wide_r[0];
  assign wide_stack_pointer    = wide_r[1];
  assign wide_stack_limit      = wide_r[2];
  assign wide_stack_base       = wide_r[3];
  assign fixed_acc_zero        = acc_r[0];
  assign fixed_acc_one         = acc_r[1];
  assign fixed_acc_two         = acc_r[2];
  assign fixed_acc_three       = acc_r[3];
  assign float_status_word     = fsr_r;
endmodule
`default_nettype wire

/* legacy_register_view_chk.sv */
// checker: port-level assertions for the legacy register view
`timescale 1ns/1ps
`default_nettype none
module legacy_register_view_chk
  import legacy_view_pkg::*;
(
  input wire logic                       mclk,
  input wire logic                       srst,
  input wire logic                       op_valid,
  input var  legacy_view_pkg::leg_op_t   op_in,
  input wire logic                       op_ready,
  input wire logic [31:0]                rd_data,
  input wire logic [14:0]                rel_offset,
  input wire logic                       fixed_fault,
  input wire logic [2:0]                 cur_segment,
  input var  legacy_view_pkg::mem_req_t  mem_req,
  input var  legacy_view_pkg::native_wr_t native_wr,
  input wire logic [15:0]                processor_status_word,
  input wire logic [31:0]                fixed_acc_zero,
  input wire logic [31:0]                fixed_acc_one,
  input wire logic [31:0]                fixed_acc_two,
  input wire logic [31:0]                fixed_acc_three,
  input wire logic [63:0]                float_status_word
);
  logic [3:0][31:0] acc_w;
  logic [3:0][31:0] acc_q;
  logic [63:0]      fsr_q;
  leg_op_t          in_q;
  logic             take;
  logic             quiet;

  assign acc_w = {fixed_acc_three, fixed_acc_two, fixed_acc_one, fixed_acc_zero};
  assign take  = op_valid && op_ready;
  // a native write in the take cycle wins, so those cycles are left out
  assign quiet = !native_wr.we;

  always_ff @(posedge mclk) begin
    acc_q <= acc_w;
    fsr_q <= float_status_word;
    in_q  <= op_in;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (srst);

  sequence sp_read;
    mem_req.valid && !mem_req.we
      && mem_req.addr == {1'b0, cur_segment, SEG_FILL, PZ_STACK_PTR};
  endsequence
  sequence frame_acc;
    mem_req.valid && mem_req.addr == {1'b0, cur_segment, SEG_FILL, PZ_FRAME_PTR};
  endsequence

  no_fault_a: assert property (fixed_fault == 1'b0)
    else $error("fixed fault raised");
  psr_keep_a: assert property (!(native_wr.we && native_wr.sel == SEL_PSR)
    |=> $stable(processor_status_word)) else $error("status word changed");
  load_half_a: assert property (take && quiet && op_in.op == op_load
    |=> acc_w[in_q.dst] == {acc_q[in_q.dst][31:16], in_q.data[15:0]})
    else $error("legacy load wrong");
  full_load_a: assert property (take && quiet && op_in.op inside {op_subroutine_jump,
    op_extended_subroutine_jump, op_extended_load_effective_addr, op_read_high_word,
    op_load_effective_addr} |=> acc_w[in_q.dst] == in_q.data) else $error("full load wrong");
  read_low_a: assert property (take && op_in.op == op_read
    |=> rd_data == {16'h0000, acc_q[in_q.dst][15:0]}) else $error("legacy read wrong");
  rel_off_a: assert property (take && op_in.op == op_rel_addr
    |=> rel_offset == acc_q[in_q.dst][14:0]) else $error("offset wrong");
  cmp_keep_a: assert property (take && quiet && op_in.op == op_compare_to_limits
    |=> acc_w == acc_q) else $error("compare altered accumulator");
  fsr_read_a: assert property (take && op_in.op == op_fsr_read
    |=> rd_data == {fsr_q[63:48], 1'b0, fsr_q[14:0]}) else $error("float status view wrong");
  sp_first_a: assert property (take && op_in.op inside {op_push, op_pop}
    |=> sp_read) else $error("stack pointer not fetched");
  frame_first_a: assert property (take && op_in.op inside {op_rd_frame, op_wr_frame}
    |=> frame_acc) else $error("frame pointer not accessed");
endmodule

bind legacy_register_view legacy_register_view_chk chk (.*);
`default_nettype wire

/* tb_legacy_register_view.sv */
// testbench: directed checks of the legacy register view
`timescale 1ns/1ps
`default_nettype none
module tb_legacy_register_view;
  import legacy_view_pkg::*;
  logic        mclk, srst, op_valid, op_ready, op_done, in_limits, carry, fixed_fault;
  logic        mem_ack, stack_fault, fp_wr_en, slow, tick;
  logic [31:0] rd_data, wide_frame_pointer, wide_stack_pointer, wide_stack_limit;
  logic [31:0] wide_stack_base, fixed_acc_zero, fixed_acc_one, fixed_acc_two, fixed_acc_three;
  logic [63:0] fp_rd_data, fp_wr_data, float_status_word;
  logic [15:0] mem_rdata, processor_status_word;
  logic [14:0] rel_offset, stack_fault_handler;
  logic [2:0]  cur_segment;
  logic [1:0]  fp_wr_sel;
  leg_op_t     op_in;
  mem_req_t    mem_req;
  native_wr_t  native_wr;
  logic [15:0] mem_w [256];
  logic [3:0][31:0] acc_all;
  int          errors, cmp_count;

  legacy_register_view DUT (.*);

  assign acc_all = {fixed_acc_three, fixed_acc_two, fixed_acc_one, fixed_acc_zero};

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic stop_test;
    if (errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // page-zero stand-in; slow mode acks every other cycle, idle data lines toggle
  // held still until reset is released, so an x clock step cannot seed tick
  always @(negedge mclk) begin
    if (srst !== 1'b0) begin
      tick      <= 1'b0;
      mem_ack   <= 1'b0;
      mem_rdata <= 16'h0000;
    end else begin
      tick <= ~tick;
      mem_ack <= mem_req.valid && !(slow && tick);
      if (mem_req.valid && !(slow && tick)) begin
        check(mem_req.addr[31:16], {1'b0, cur_segment, 12'h000});
        if (mem_req.we) mem_w[mem_req.addr[7:0]] <= mem_req.wdata;
      end
      mem_rdata <= (mem_req.valid && !mem_req.we) ? mem_w[mem_req.addr[7:0]] : ~mem_rdata;
    end
  end

  task automatic run(input op_t op, input logic [1:0] d, input logic [1:0] s,
                     input logic [31:0] data, input logic [63:0] fd = 64'h0);
    int n;
    n = 0;
    // one edge between requests: valid is never lowered and raised in one step
    @(negedge mclk);
    while (op_ready !== 1'b1 && n < 50) begin
      @(negedge mclk);
      n++;
    end
    op_valid = 1'b1;
    op_in = '{op, d, s, data, fd};
    @(negedge mclk);
    op_valid = 1'b0;
    while (op_done !== 1'b1 && stack_fault !== 1'b1 && n < 50) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 50) begin
      errors++;
      stop_test;
    end
  endtask

  task automatic nat(input logic [3:0] sel, input logic [31:0] d);
    native_wr = '{1'b1, sel, d};
    @(negedge mclk);
    native_wr.we = 1'b0;
    @(negedge mclk);
  endtask

  task automatic t_fixed;
    op_t fl [5];
    fl = '{op_extended_subroutine_jump, op_extended_load_effective_addr,
           op_read_high_word, op_subroutine_jump, op_load_effective_addr};
    nat(4'h1, 32'h1234_5678);
    run(op_load, 2'h1, 2'h0, 32'h0000_beef);
    check(fixed_acc_one, 32'h1234_beef);
    run(op_read, 2'h1, 2'h0, 32'h0);
    check(rd_data, 32'h0000_beef);
    run(op_rel_addr, 2'h1, 2'h0, 32'h0);
    check(rel_offset, 15'h3eef);
    run(op_compare_to_limits, 2'h1, 2'h1, 32'h0000_8000);
    check(in_limits, 1'b1);
    check(fixed_acc_one, 32'h1234_beef);
    run(op_compare_to_limits, 2'h1, 2'h1, 32'h7fff_0000);
    check(in_limits, 1'b0);
    for (int i = 0; i < 5; i++) begin
      run(fl[i], i[1:0], 2'h0, 32'hc0de_0000 + i);
      check(acc_all[i[1:0]], 32'hc0de_0000 + i);
    end
  endtask

  task automatic t_arith;
    nat(4'h0, 32'h0000_0001);
    nat(4'h1, 32'h0000_0001);
    run(op_add, 2'h1, 2'h0, 32'h0);
    check(fixed_acc_one, 32'h0000_0002);
    check(carry, 1'b0);
    nat(4'h2, 32'h0);
    run(op_div, 2'h2, 2'h2, 32'h0);
    check(fixed_acc_two, 32'h0);
    check(carry, 1'b1);
    run(op_add, 2'h1, 2'h0, 32'h0);
    check(carry, 1'b0);
    // carry now clear, so the next sum is exact whatever carry-in does
    nat(4'h0, 32'h0000_ffff);
    nat(4'h1, 32'h7777_0001);
    run(op_add, 2'h1, 2'h0, 32'h0);
    check(fixed_acc_one, 32'h7777_0000);
    check(carry, 1'b1);
    // 0000 - ffff borrows: low half 0001, no carry out of the 16-bit sum
    run(op_sub, 2'h1, 2'h0, 32'h0);
    check(fixed_acc_one, 32'h7777_0001);
    check(carry, 1'b0);
  endtask

  task automatic t_float;
    fp_wr_sel = 2'h2;
    fp_wr_data = 64'h0123_4567_89ab_cdef;
    fp_wr_en = 1'b1;
    @(negedge mclk);
    fp_wr_en = 1'b0;
    run(op_fp_read, 2'h0, 2'h2, 32'h0);
    check(fp_rd_data, 64'h0123_4567_89ab_cdef);
    run(op_fp_load, 2'h3, 2'h0, 32'h0, 64'hfedc_ba98_7654_3210);
    run(op_fp_read, 2'h0, 2'h3, 32'h0);
    check(fp_rd_data, 64'hfedc_ba98_7654_3210);
    run(op_fsr_write, 2'h0, 2'h0, 32'hffff_ffff);
    check(float_status_word, 64'hffff_0000_0000_7fff);
    run(op_fsr_read, 2'h0, 2'h0, 32'h0);
    check(rd_data, 32'hffff_7fff);
  endtask

  task automatic t_stack;
    cur_segment = 3'h3;
    slow = 1'b1;
    mem_w[8'h20] = 16'h0050;
    mem_w[8'h21] = 16'h0abc;
    mem_w[8'h22] = 16'h0060;
    nat(4'h0, 32'h0000_1111);
    run(op_push, 2'h0, 2'h0, 32'h0);
    check(mem_w[8'h51], 16'h1111);
    check(mem_w[8'h20], 16'h0051);
    run(op_pop, 2'h1, 2'h0, 32'h0);
    check(fixed_acc_one[15:0], 16'h1111);
    check(mem_w[8'h20], 16'h0050);
    run(op_rd_frame, 2'h2, 2'h0, 32'h0);
    check(fixed_acc_two[15:0], 16'h0abc);
    run(op_wr_frame, 2'h0, 2'h0, 32'h0);
    check(mem_w[8'h21], 16'h1110);
    // pointer at the limit: push must fault through one indirect hop
    mem_w[8'h20] = 16'h0060;
    mem_w[8'h61] = 16'h0000;
    mem_w[8'h23] = 16'h8030;
    mem_w[8'h30] = 16'h0045;
    slow = 1'b0;
    run(op_push, 2'h0, 2'h0, 32'h0);
    check(stack_fault, 1'b1);
    check(stack_fault_handler, 15'h0045);
    check(mem_w[8'h61], 16'h0000);
  endtask

  initial begin
    errors = 0;
    cmp_count = 0;
    srst = 1'b1;
    op_valid = 1'b0;
    op_in = '0;
    native_wr = '0;
    fp_wr_en = 1'b0;
    fp_wr_sel = 2'h0;
    fp_wr_data = 64'h0;
    cur_segment = 3'h0;
    slow = 1'b0;
    // rising edges only: the time-zero clock step must not count as one
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    srst = 1'b0;
    nat(4'h8, 32'h0000_5a5a);
    for (int k = 0; k < 4; k++) nat(4'h4 + k[3:0], 32'hc0c0_0000 + k);
    t_fixed;
    t_arith;
    t_float;
    t_stack;
    check(processor_status_word, 16'h5a5a);
    check(fixed_fault, 1'b0);
    check({wide_frame_pointer, wide_stack_pointer}, 64'hc0c0_0000_c0c0_0001);
    check({wide_stack_limit, wide_stack_base}, 64'hc0c0_0002_c0c0_0003);
    stop_test;
  end
endmodule
`default_nettype wire
